//--- src/gdsc_device.sv
// gate driver control core: power states, fault response and serial target
`timescale 1ns/100ps
`include "gdsc_regs.svh"
module gdsc_device (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // serial link
  gdsc_link_if.device link,
  // supplies and pins
  input wire logic sleep_request_n_i,
  input wire logic logic_supply_ok_i,
  input wire logic power_supply_ok_i,
  input wire logic driver_off_pin_i,
  input wire logic thermal_shutdown_i,
  input wire logic pin_variant_i,
  // outputs
  output logic gate_drive_o,
  output logic gate_pulldown_o,
  output logic gate_semi_pulldown_o,
  output logic charge_pump_en_o,
  output logic current_sense_en_o,
  output logic fault_out_n_o,
  output gdsc_pkg::gdsc_state_e state_o
);
  import gdsc_pkg::*;
  gdsc_state_e state;
  logic [4:0] wake_cnt;
  logic [2:0] sclk_s, cs_s, sdi_s;
  logic [4:0] bit_cnt;
  gdsc_word_t rx, tx;
  logic [7:0] ctrl;
  logic thermal_shutdown_flag, clock_count_error_flag, cs_prev;
  logic awake, sclk_rise, sclk_fall, cs_low, frame_end, frame_ok;
  // only a change agreed by stages two and three counts
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      sclk_s <= 3'h0;
      cs_s <= 3'h7;
      sdi_s <= 3'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      cs_s <= {cs_s[1:0], link.cs_n};
      sdi_s <= {sdi_s[1:0], link.sdi};
    end
  end
  assign cs_low = !cs_s[1] && !cs_s[2];
  assign sclk_rise = cs_low && sclk_s[1] && !sclk_s[2];
  assign sclk_fall = cs_low && !sclk_s[1] && sclk_s[2];
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) cs_prev <= 1'b1;
    else cs_prev <= cs_low ? 1'b0 : (cs_s[1] && cs_s[2]) ? 1'b1 : cs_prev;
  end
  assign frame_end = !cs_prev && cs_s[1] && cs_s[2];
  assign frame_ok = frame_end && bit_cnt == `GDSC_FRAME_BITS && !rx[15];
  assign awake = sleep_request_n_i && logic_supply_ok_i;
  // power state sequencer
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state <= GDSC_SLEEP;
      wake_cnt <= 5'h00;
    end else if (!awake) begin
      state <= GDSC_SLEEP;
      wake_cnt <= 5'h00;
    end else begin
      unique case (state)
        GDSC_SLEEP: state <= GDSC_WAKE;
        GDSC_WAKE: begin
          wake_cnt <= wake_cnt + 5'h01;
          if (wake_cnt == 5'(`GDSC_WAKE_CYC - 1)) state <= GDSC_STANDBY;
        end
        GDSC_STANDBY: if (power_supply_ok_i) state <= GDSC_OPER;
        GDSC_OPER: if (!power_supply_ok_i) state <= GDSC_STANDBY;
      endcase
    end
  end
  // serial receive and transmit shift, core active only when awake
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || state == GDSC_SLEEP || state == GDSC_WAKE) begin
      bit_cnt <= 5'h00;
      rx <= 16'h0000;
      tx <= 16'h0000;
    end else if (cs_s[1] && cs_s[2]) begin
      bit_cnt <= 5'h00;
      tx <= {2'h3, !fault_out_n_o, 4'h0, thermal_shutdown_flag, 8'h00};
    end else if (sclk_fall) begin
      rx <= {rx[14:0], sdi_s[2]};
      if (bit_cnt != 5'h1F) bit_cnt <= bit_cnt + 5'h01;
      // after seven shifts the report byte must sit just below the outgoing bit
      if (bit_cnt == 5'd7) tx[14:7] <= rx[5] ? rd_data({rx[4:0], sdi_s[2]}) : 8'h00;
    end else if (sclk_rise && bit_cnt != 5'h00) begin
      tx <= {tx[14:0], 1'b0};
    end
  end
  function automatic logic [7:0] rd_data(input logic [5:0] a);
    unique case (a)
      `GDSC_ADDR_STAT1: rd_data = {2'h3, !fault_out_n_o, 4'h0, thermal_shutdown_flag};
      `GDSC_ADDR_STAT2: rd_data = {4'h0, thermal_shutdown_flag, 1'b0, clock_count_error_flag, 1'b0};
      `GDSC_ADDR_CTRL: rd_data = ctrl;
      default: rd_data = 8'h00;
    endcase
  endfunction : rd_data
  // control register: writes taken only on a whole frame
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || state == GDSC_SLEEP) ctrl <= `GDSC_CTRL_RESET;
    else if (frame_ok && !rx[`GDSC_RW_BIT] && rx[`GDSC_ADDR_HI:`GDSC_ADDR_LO] == `GDSC_ADDR_CTRL)
      ctrl <= {rx[7:1], 1'b0};
  end
  wire clr_req = frame_ok && !rx[`GDSC_RW_BIT] && rx[`GDSC_ADDR_HI:`GDSC_ADDR_LO] == `GDSC_ADDR_CTRL
    && rx[`GDSC_CTRL_CLR_BIT];
  // set wins over clear
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || state == GDSC_SLEEP) thermal_shutdown_flag <= 1'b0;
    else if (thermal_shutdown_i) thermal_shutdown_flag <= 1'b1;
    else if (clr_req) thermal_shutdown_flag <= 1'b0;
  end
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || state == GDSC_SLEEP) clock_count_error_flag <= 1'b0;
    else if (frame_end && bit_cnt != `GDSC_FRAME_BITS) clock_count_error_flag <= 1'b1;
    else if (clr_req) clock_count_error_flag <= 1'b0;
  end
  // outputs from flip-flops
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      gate_drive_o <= 1'b0;
      gate_pulldown_o <= 1'b1;
      gate_semi_pulldown_o <= 1'b0;
      charge_pump_en_o <= 1'b0;
      current_sense_en_o <= 1'b0;
      fault_out_n_o <= 1'b1;
      state_o <= GDSC_SLEEP;
      link.sdo <= 1'b0;
      link.sdo_oe <= 1'b0;
    end else begin
      gate_drive_o <= state == GDSC_OPER && (ctrl[`GDSC_CTRL_EN_BIT] || pin_variant_i)
        && !driver_off_pin_i && !thermal_shutdown_flag;
      gate_pulldown_o <= state == GDSC_SLEEP || driver_off_pin_i;
      gate_semi_pulldown_o <= thermal_shutdown_flag || state == GDSC_STANDBY;
      charge_pump_en_o <= state == GDSC_OPER && !thermal_shutdown_flag;
      current_sense_en_o <= state == GDSC_OPER && !thermal_shutdown_flag;
      fault_out_n_o <= !thermal_shutdown_flag;
      state_o <= state;
      link.sdo <= tx[15];
      link.sdo_oe <= cs_low;
    end
  end
endmodule : gdsc_device

//--- src/gdsc_regs.svh
// register offsets, status layout and timing counts for the gate driver core
// How it works
// - sleep pin low or reset: sleep, all off
// - sleep holds gates with passive pull-downs
// - awake and supply good: standby after wake delay
// - pump and drivers off until supply undervoltage clears
// - standby takes programming, reports faults, no driving
// - operating state when both supply conditions hold
// - drivers start only after enable bit set
// - pin variant enables drivers automatically when operating
// - driver-off pin pulls gates down, no fault
// - thermal shutdown latches, disables pump, sense, gates
// - serial port is only a target
// - frame is command byte then data byte
// - reply carries status byte first, then data
// - controller keeps clock low at select edges
// - controller raises select between words
// - select high ignores clock, data out released
// - sample on falling edge, launch on rising
// - most significant bit first both ways
// - clock count not sixteen discards the frame
// - bit15 zero, bit14 read flag, address, data
// - write replies zeros, read replies register contents
`ifndef GDSC_REGS_SVH
`define GDSC_REGS_SVH
`define GDSC_FRAME_BITS 5'd16
`define GDSC_RW_BIT 14
`define GDSC_ADDR_HI 13
`define GDSC_ADDR_LO 8
`define GDSC_ADDR_STAT1 6'h00
`define GDSC_ADDR_STAT2 6'h02
`define GDSC_ADDR_CTRL 6'h04
`define GDSC_CTRL_RESET 8'h00
`define GDSC_CTRL_EN_BIT 7
`define GDSC_CTRL_CLR_BIT 0
`define GDSC_STAT2_THERMAL_SHUTDOWN_FLAG_BIT 3
`define GDSC_STAT2_CNT_BIT 1
`define GDSC_WAKE_NS 1000
`define GDSC_CLK_NS 50
`define GDSC_WAKE_CYC ((`GDSC_WAKE_NS + `GDSC_CLK_NS - 1) / `GDSC_CLK_NS)
`define GDSC_SCLK_DIV 4
`endif

//--- src/gdsc_pkg.sv
// types shared by both ends
package gdsc_pkg;
  typedef enum logic [1:0] {GDSC_SLEEP, GDSC_WAKE, GDSC_STANDBY, GDSC_OPER} gdsc_state_e;
  typedef logic [15:0] gdsc_word_t;
endpackage : gdsc_pkg

//--- src/gdsc_link_if.sv
// serial link between controller and gate driver
`timescale 1ns/100ps
interface gdsc_link_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  modport device (input sclk, input cs_n, input sdi, output sdo, output sdo_oe);
  modport host (output sclk, output cs_n, output sdi, input sdo, input sdo_oe);
endinterface : gdsc_link_if

//--- src/gdsc_host.sv
// controller end: sends one 16-bit word per request and returns the reply
`timescale 1ns/100ps
`include "gdsc_regs.svh"
module gdsc_host (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // serial link
  gdsc_link_if.host link,
  // user side
  input wire logic req_i,
  input wire gdsc_pkg::gdsc_word_t word_i,
  output logic busy_o,
  output logic done_o,
  output gdsc_pkg::gdsc_word_t reply_o
);
  import gdsc_pkg::*;
  gdsc_word_t sh, rx;
  logic [5:0] phase;
  logic [2:0] div;
  logic [2:0] sdo_s;
  logic active;
  // sdo comes from the other party, so it is synchronised
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) sdo_s <= 3'h0;
    else sdo_s <= {sdo_s[1:0], link.sdo};
  end
  // slow divided clock so the device's three-stage sampling keeps up
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      active <= 1'b0;
      phase <= 6'h00;
      div <= 3'h0;
      sh <= 16'h0000;
      rx <= 16'h0000;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.sdi <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      reply_o <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      if (!active) begin
        if (req_i) begin
          active <= 1'b1;
          busy_o <= 1'b1;
          sh <= {1'b0, word_i[14:0]};
          link.cs_n <= 1'b0;
          link.sdi <= 1'b0;
          phase <= 6'h00;
          div <= 3'h0;
        end
      end else if (div != 3'(`GDSC_SCLK_DIV * 2 - 1)) begin
        div <= div + 3'h1;
      end else begin
        div <= 3'h0;
        phase <= phase + 6'h01;
        if (phase < 6'd32) begin
          link.sclk <= !phase[0];
          if (!phase[0]) link.sdi <= sh[15];
          if (!phase[0]) sh <= {sh[14:0], 1'b0};
          if (phase[0]) rx <= {rx[14:0], sdo_s[2]};
        end else if (phase == 6'd32) begin
          link.cs_n <= 1'b1;
        end else if (phase == 6'd34) begin
          active <= 1'b0;
          busy_o <= 1'b0;
          done_o <= 1'b1;
          reply_o <= rx;
        end
      end
    end
  end
endmodule : gdsc_host

//--- tb/gdsc_link_asserts.sv
// serial link protocol assertions between controller and gate driver
`timescale 1ns/100ps
module gdsc_link_asserts (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo_oe
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  logic [5:0] falls;
  // counts falling link clock edges within one frame
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || cs_n) begin
      falls <= 6'h00;
    end else if ($fell(sclk)) begin
      falls <= falls + 6'h01;
    end
  end
  sequence s_high_phase;
    sclk [*8];
  endsequence
  a_sixteen_falls: assert property ($rose(cs_n) |-> falls == 6'h10)
    else $error("frame without sixteen clock falls");
  a_half_period: assert property ($rose(sclk) |-> s_high_phase)
    else $error("link clock high phase too short");
  a_clk_low_fall: assert property ($fell(cs_n) |-> !sclk)
    else $error("clock high at select fall");
  a_clk_low_rise: assert property ($rose(cs_n) |-> !sclk && !$past(sclk))
    else $error("clock high at select rise");
  a_select_gap: assert property ($rose(cs_n) |=> cs_n)
    else $error("no select gap between words");
  a_sdi_on_rise: assert property (!cs_n && !$fell(cs_n) && $changed(sdi) |-> $rose(sclk))
    else $error("data changed off the rising clock");
  a_oe_idle: assert property (cs_n [*5] |-> !sdo_oe)
    else $error("data out driven while deselected");
  a_oe_frame: assert property (!cs_n [*8] |-> sdo_oe)
    else $error("data out not driven in frame");
endmodule : gdsc_link_asserts

//--- tb/gdsc_tb.sv
// self-checking bench joining controller and gate driver ends
`timescale 1ns/100ps
module gdsc_tb;
  import gdsc_pkg::*;
  logic ref_clk_i = 0, resetn_i = 0, sleep_n = 1, psup = 0, doff = 0, therm = 0, req = 0;
  logic busy, done, gate, pd, semi, cp, cs, fault_n, gate2;
  gdsc_word_t word = 16'h0000, reply, r;
  gdsc_state_e state;
  int mismatches = 0, checks = 0, cyc = 0;
  gdsc_link_if link ();
  gdsc_link_if link2 ();
  always #25 ref_clk_i = ~ref_clk_i;
  gdsc_host gdsc_host_inst (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(link), .req_i(req),
    .word_i(word), .busy_o(busy), .done_o(done), .reply_o(reply));
  gdsc_device gdsc_device_inst (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(link),
    .sleep_request_n_i(sleep_n), .logic_supply_ok_i(1'b1), .power_supply_ok_i(psup), .driver_off_pin_i(doff),
    .thermal_shutdown_i(therm), .pin_variant_i(1'b0), .gate_drive_o(gate), .gate_pulldown_o(pd),
    .gate_semi_pulldown_o(semi), .charge_pump_en_o(cp), .current_sense_en_o(cs), .fault_out_n_o(fault_n),
    .state_o(state));
  // second device, pin variant, fed by a bench driver that can break framing
  gdsc_device gdsc_device_inst2 (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(link2),
    .sleep_request_n_i(sleep_n), .logic_supply_ok_i(1'b1), .power_supply_ok_i(psup), .driver_off_pin_i(doff),
    .thermal_shutdown_i(therm), .pin_variant_i(1'b1), .gate_drive_o(gate2), .gate_pulldown_o(),
    .gate_semi_pulldown_o(), .charge_pump_en_o(), .current_sense_en_o(), .fault_out_n_o(), .state_o());
  gdsc_link_asserts gdsc_link_asserts_inst (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sclk(link.sclk),
    .cs_n(link.cs_n), .sdi(link.sdi), .sdo_oe(link.sdo_oe));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic xfer(input gdsc_word_t w);
    word = w;
    req = 1'b1;
    @(negedge ref_clk_i);
    req = 1'b0;
    for (int i = 0; i < 600 && done !== 1'b1; i++) @(negedge ref_clk_i);
    r = reply;
    repeat (8) @(negedge ref_clk_i);
  endtask : xfer
  // n link clocks on the second link; sdo read late in each low phase
  task automatic bb(input int n, input gdsc_word_t w);
    link2.cs_n = 1'b0;
    for (int i = 0; i <= n; i++) begin
      repeat (4) @(negedge ref_clk_i);
      if (i > 0) r[16 - i] = link2.sdo;
      if (i == n) break;
      link2.sclk = 1'b1;
      link2.sdi = w[15 - i];
      repeat (4) @(negedge ref_clk_i);
      link2.sclk = 1'b0;
    end
    link2.cs_n = 1'b1;
    repeat (12) @(negedge ref_clk_i);
  endtask : bb
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    link2.cs_n = 1'b1;
    link2.sclk = 1'b0;
    link2.sdi = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    repeat (40) @(negedge ref_clk_i);
    chk("standby", state, GDSC_STANDBY);
    chk("pump before uv", cp, 0);
    xfer(16'h0480);
    chk("write reply", r & 16'hC0FF, 16'hC000);
    chk("standby gate", gate, 0);
    chk("host idle", busy, 0);
    psup = 1'b1;
    repeat (10) @(negedge ref_clk_i);
    chk("operating", state, GDSC_OPER);
    chk("gate enabled", gate, 1);
    chk("auto gate", gate2, 1);
    xfer(16'h4400);
    chk("ctrl read", r & 16'hC0FF, 16'hC080);
    doff = 1'b1;
    repeat (10) @(negedge ref_clk_i);
    chk("driver off", {gate, pd, cp, fault_n}, 4'b0111);
    doff = 1'b0;
    therm = 1'b1;
    repeat (10) @(negedge ref_clk_i);
    chk("shutdown", {cp, cs, semi, fault_n}, 4'b0010);
    therm = 1'b0;
    xfer(16'h4200);
    chk("shutdown flag", {r[3], fault_n}, 2'b10);
    xfer(16'h0401);
    chk("fault cleared", fault_n, 1);
    // short frame must leave ctrl untouched and flag the count
    bb(15, 16'h0480);
    bb(16, 16'h4200);
    chk("count flag", r[1], 1);
    bb(16, 16'h4400);
    chk("ctrl unchanged", r[7:0], 0);
    sleep_n = 1'b0;
    repeat (10) @(negedge ref_clk_i);
    chk("sleep", {state, gate, pd}, {GDSC_SLEEP, 2'b01});
    tally_and_finish();
  end
endmodule : gdsc_tb
